// ===== pkg/utopia_rx_defines.vh
`ifndef UTOPIA_RX_DEFINES_VH
`define UTOPIA_RX_DEFINES_VH
`define ADDR_WIDTH 5
`define DATA_WIDTH 8
`define ADDR_RESET 5'h00
`define POLL_LAST 5'h1f
`define MODE_SMII_LANE 7
`endif

// ===== rtl/utopia_rx_phy_select_port.v
`include "utopia_rx_defines.vh"
module utopia_rx_phy_select_port #(
   parameter ADDR_WIDTH = `ADDR_WIDTH,
   parameter DATA_WIDTH = `DATA_WIDTH
) (
   // Clock and reset.
   input wire sys_clk,
   input wire reset,
   // Mode controls.
   input wire interface_enable,
   input wire smii_mode,
   input wire source_sync_mode,
   input wire multi_phy_mode,
   input wire single_phy_mode,
   // Upper-layer request.
   input wire select_req,
   input wire [ADDR_WIDTH-1:0] select_addr,
   input wire rx_ready,
   // Pins from PHY.
   input wire [DATA_WIDTH-1:0] shared_rx_lane,
   input wire cell_rx_start_of_cell,
   input wire serial_ref_clk_125,
   input wire source_sync_rx_clk,
   // Pins to PHY.
   output reg [ADDR_WIDTH-1:0] rx_phy_addr_bus,
   output reg rx_phy_addr_oe,
   output reg rx_flow_enable_out,
   output reg rx_flow_enable_oe,
   // Received data and PHY selection status to upper layer.
   output reg serial_rx_port4_data,
   output reg serial_rx_valid,
   output reg [DATA_WIDTH-1:0] cell_rx_data,
   output reg cell_rx_soc,
   output reg [ADDR_WIDTH-1:0] selected_phy,
   output reg select_done
);
   localparam ST_IDLE = 2'b01;
   localparam ST_SEL = 2'b10;
   localparam [ADDR_WIDTH-1:0] ADDR_RESET_VALUE = `ADDR_RESET;
   localparam [DATA_WIDTH-1:0] DATA_ZERO = {DATA_WIDTH{1'b0}};
   // Pins and external clocks come from another domain, so each passes two flip-flops.
   wire [DATA_WIDTH-1:0] lane_s2;
   reg soc_s1;
   reg soc_s2;
   reg ref_s1;
   reg ref_s2;
   reg ref_s3;
   reg ssc_s1;
   reg ssc_s2;
   reg ssc_s3;
   reg [1:0] state;
   reg [1:0] next_state;
   reg [ADDR_WIDTH-1:0] next_addr;
   reg next_addr_oe;
   reg next_flow;
   reg next_flow_oe;
   reg [ADDR_WIDTH-1:0] next_selected;
   reg next_done;
   reg [DATA_WIDTH-1:0] next_cell_data;
   reg next_cell_soc;
   reg next_serial_data;
   reg next_serial_valid;
   wire utopia_active;
   wire serial_active;
   wire serial_clk;
   wire serial_clk_d;
   wire serial_rise;
   assign utopia_active = interface_enable & ~smii_mode;
   assign serial_active = interface_enable & smii_mode;
   assign serial_clk = source_sync_mode ? ssc_s2 : ref_s2;
   assign serial_clk_d = source_sync_mode ? ssc_s3 : ref_s3;
   assign serial_rise = serial_clk & ~serial_clk_d;
   genvar bit_idx;
   generate
      for (bit_idx = 0; bit_idx < DATA_WIDTH; bit_idx = bit_idx + 1) begin : lane_sync
         reg stage1;
         reg stage2;
         always @(posedge sys_clk or posedge reset) begin
            if (reset) begin
               stage1 <= 1'b0;
               stage2 <= 1'b0;
            end else begin
               stage1 <= shared_rx_lane[bit_idx];
               stage2 <= stage1;
            end
         end
         assign lane_s2[bit_idx] = stage2;
      end
   endgenerate
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         soc_s1 <= 1'b0;
         soc_s2 <= 1'b0;
      end else begin
         soc_s1 <= cell_rx_start_of_cell;
         soc_s2 <= soc_s1;
      end
   end
   // The third stage only remembers the last settled level for edge detection.
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ref_s1 <= 1'b0;
         ref_s2 <= 1'b0;
         ref_s3 <= 1'b0;
      end else begin
         ref_s1 <= serial_ref_clk_125;
         ref_s2 <= ref_s1;
         ref_s3 <= ref_s2;
      end
   end
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ssc_s1 <= 1'b0;
         ssc_s2 <= 1'b0;
         ssc_s3 <= 1'b0;
      end else begin
         ssc_s1 <= source_sync_rx_clk;
         ssc_s2 <= ssc_s1;
         ssc_s3 <= ssc_s2;
      end
   end
   // A real 125 MHz clock cannot be oversampled at 25 MHz; edges are found only for slow link clocks.
   always @* begin
      next_serial_data = serial_rx_port4_data;
      next_serial_valid = 1'b0;
      if (serial_active && serial_rise) begin
         next_serial_data = lane_s2[`MODE_SMII_LANE];
         next_serial_valid = 1'b1;
      end
   end
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         serial_rx_port4_data <= 1'b0;
         serial_rx_valid <= 1'b0;
      end else begin
         serial_rx_port4_data <= next_serial_data;
         serial_rx_valid <= next_serial_valid;
      end
   end
   // Cell lanes share the synchroniser latency with start of cell, so the two stay aligned.
   always @* begin
      next_cell_data = cell_rx_data;
      next_cell_soc = 1'b0;
      if (utopia_active) begin
         next_cell_data = lane_s2;
         next_cell_soc = soc_s2;
      end
   end
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cell_rx_data <= DATA_ZERO;
         cell_rx_soc <= 1'b0;
      end else begin
         cell_rx_data <= next_cell_data;
         cell_rx_soc <= next_cell_soc;
      end
   end
   // PHY selection; a request in the select cycle is dropped, so requests come every two cycles.
   always @* begin
      next_state = state;
      next_addr = rx_phy_addr_bus;
      next_addr_oe = rx_phy_addr_oe;
      next_flow = rx_flow_enable_out;
      next_flow_oe = rx_flow_enable_oe;
      next_selected = selected_phy;
      next_done = 1'b0;
      if (!utopia_active) begin
         next_state = ST_IDLE;
         next_addr_oe = 1'b0;
         next_flow_oe = 1'b0;
         next_flow = 1'b0;
      end else begin
         next_flow_oe = 1'b1;
         next_addr_oe = multi_phy_mode;
         if (multi_phy_mode) begin
            case (state)
               ST_IDLE: begin
                  next_flow = 1'b0;
                  if (select_req) begin
                     next_addr = select_addr;
                     next_flow = 1'b1;
                     next_state = ST_SEL;
                  end
               end
               ST_SEL: begin
                  next_flow = 1'b0;
                  next_selected = rx_phy_addr_bus;
                  next_done = 1'b1;
                  next_state = ST_IDLE;
               end
               default: begin
                  next_flow = 1'b0;
                  next_state = ST_IDLE;
               end
            endcase
         end else begin
            next_state = ST_IDLE;
            next_flow = single_phy_mode & rx_ready;
         end
      end
   end
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state <= ST_IDLE;
         rx_phy_addr_bus <= ADDR_RESET_VALUE;
         rx_phy_addr_oe <= 1'b0;
         rx_flow_enable_out <= 1'b0;
         rx_flow_enable_oe <= 1'b0;
         selected_phy <= ADDR_RESET_VALUE;
         select_done <= 1'b0;
      end else begin
         state <= next_state;
         rx_phy_addr_bus <= next_addr;
         rx_phy_addr_oe <= next_addr_oe;
         rx_flow_enable_out <= next_flow;
         rx_flow_enable_oe <= next_flow_oe;
         selected_phy <= next_selected;
         select_done <= next_done;
      end
   end
endmodule

// ===== verification/utopia_rx_monitor.sv
module utopia_rx_monitor(input wire sys_clk, reset, interface_enable, smii_mode, source_sync_mode, multi_phy_mode,
   single_phy_mode, select_req, rx_ready, serial_ref_clk_125, source_sync_rx_clk, rx_phy_addr_oe, rx_flow_enable_out,
   rx_flow_enable_oe, serial_rx_valid, select_done, input wire [4:0] select_addr, rx_phy_addr_bus, selected_phy);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   wire go = interface_enable && multi_phy_mode && !smii_mode;
   a_sel_drive: assert property (go && select_req && !rx_flow_enable_out |=> rx_flow_enable_out &&
      rx_phy_addr_bus == $past(select_addr)) else $error("select drive");
   a_flow_pulse: assert property (go && $past(go) && rx_flow_enable_out |=> !rx_flow_enable_out && select_done &&
      selected_phy == $past(rx_phy_addr_bus)) else $error("flow pulse");
   a_oe_off: assert property (!interface_enable && !$past(interface_enable) |-> !rx_phy_addr_oe &&
      !rx_flow_enable_oe) else $error("oe off");
   a_smii_quiet: assert property (smii_mode && $past(smii_mode) |-> !rx_flow_enable_oe) else $error("smii");
   a_ready_copy: assert property (interface_enable && single_phy_mode && !multi_phy_mode && !smii_mode |=>
      rx_flow_enable_out == $past(rx_ready))
      else $error("ready");
   a_valid_once: assert property (serial_rx_valid |=> !serial_rx_valid) else $error("valid");
   a_ref_edge: assert property (interface_enable && smii_mode && !source_sync_mode && $rose(serial_ref_clk_125) |-> ##[2:4]
      serial_rx_valid) else $error("ref edge");
   a_sync_edge: assert property (interface_enable && smii_mode && source_sync_mode && $rose(source_sync_rx_clk) |-> ##[2:4]
      serial_rx_valid) else $error("sync edge");
   cover property (select_done ##2 select_done);
   cover property (serial_rx_valid && source_sync_mode);
   cover property (single_phy_mode && rx_flow_enable_out);
endmodule
bind utopia_rx_phy_select_port utopia_rx_monitor mon_u(.*);

// ===== verification/phy_partner_model.sv
module phy_partner_model(input wire sys_clk, rx_flow_enable_out, input wire [4:0] rx_phy_addr_bus,
   output logic serial_clk, output wire [7:0] lane, output wire soc);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] sel = 5'h00;
   logic sbit = 1'b1;
   initial serial_clk = 1'b0;
   // An unselected PHY releases lanes 0 to 6, so the pull-ups read back as ones; lane 7 carries the serial bit.
   assign lane = (sel == 5'h03) ? 8'h43 : {sbit, 7'h7f};
   // Only the selected PHY raises start of cell; otherwise the line rests low.
   assign soc = (sel == 5'h03);
   always @(posedge sys_clk) if (rx_flow_enable_out) sel <= rx_phy_addr_bus;
   task send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         sbit = b[i];
         #160 serial_clk = 1'b1;
         #160 serial_clk = 1'b0;
      end
      sbit = 1'b1;
   endtask
endmodule

// ===== verification/utopia_rx_phy_select_port_tb_top.sv
module utopia_rx_phy_select_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, reset = 1, interface_enable = 0, smii_mode = 0, source_sync_mode = 0, multi_phy_mode = 0;
   logic single_phy_mode = 0, select_req = 0, rx_ready = 0, sclk, rx_phy_addr_oe, rx_flow_enable_out;
   logic rx_flow_enable_oe, serial_rx_port4_data, serial_rx_valid, cell_rx_soc, select_done, soc_pin;
   logic [4:0] select_addr = 5'h00, rx_phy_addr_bus, selected_phy;
   logic [7:0] lane, cell_rx_data;
   int num_errors = 0, check_count = 0, cyc = 0;
   always #20 sys_clk = ~sys_clk;
   phy_partner_model part_u(.sys_clk(sys_clk), .rx_flow_enable_out(rx_flow_enable_out),
      .rx_phy_addr_bus(rx_phy_addr_bus), .serial_clk(sclk), .lane(lane), .soc(soc_pin));
   utopia_rx_phy_select_port dut_u(.*, .shared_rx_lane(lane), .cell_rx_start_of_cell(soc_pin),
      .serial_ref_clk_125(source_sync_mode ? 1'b0 : sclk), .source_sync_rx_clk(source_sync_mode ? sclk : 1'b0));
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask
   task t_serial(input logic ss);
      logic [7:0] got;
      smii_mode = 1;
      source_sync_mode = ss;
      fork
         part_u.send(8'h4b);
         repeat (8) @(posedge sys_clk iff serial_rx_valid) got = {got[6:0], serial_rx_port4_data};
      join
      tick(1);
      chk("serial", 8'h4b, got);
   endtask
   task t_select;
      smii_mode = 0;
      multi_phy_mode = 1;
      select_addr = 5'h1f;
      select_req = 1;
      tick(1);
      chk("addr", 8'hdf, {rx_flow_enable_out, rx_phy_addr_oe, 1'b0, rx_phy_addr_bus});
      select_addr = 5'h03;
      tick(1);
      chk("done", 8'hbf, {select_done, rx_flow_enable_out, 1'b1, selected_phy});
      tick(1);
      chk("again", 8'h83, {rx_flow_enable_out, 2'b00, rx_phy_addr_bus});
      select_req = 0;
      tick(6);
      chk("cell", 8'h43, cell_rx_data);
      chk("soc", 8'h01, cell_rx_soc);
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge sys_clk) if (++cyc > 3000) begin
      num_errors++;
      end_of_test();
   end
   initial begin
      tick(2);
      reset = 0;
      multi_phy_mode = 1;
      select_req = 1;
      tick(3);
      chk("off", 8'h00, {rx_phy_addr_oe, rx_flow_enable_oe});
      select_req = 0;
      interface_enable = 1;
      t_serial(0);
      t_serial(1);
      t_select;
      multi_phy_mode = 0;
      single_phy_mode = 1;
      rx_ready = 1;
      tick(2);
      chk("ready", 8'h01, rx_flow_enable_out);
      end_of_test();
   end
endmodule
